// ### pcfc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pcfc_assertions #(
   parameter int QUEUE_DEPTH = 2
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [3:0] cmd_op,
   input wire logic evt_valid,
   input wire logic evt_ready,
   input wire logic [3:0] evt_code,
   input wire logic [7:0] evt_arg,
   input wire logic [7:0] evt_open,
   input wire logic [7:0] evt_closed
);
   // ----------------------------------------------------------------
   // Helper state
   // ----------------------------------------------------------------
   logic started;
   logic sys_pend;
   logic [3:0] last_op;
   logic take;
   logic is_data;
   logic done_evt;
   assign take = cmd_valid && cmd_ready;
   assign is_data = cmd_op == pcfc_pkg::PCFC_CMD_TRANSMIT ||
      cmd_op == pcfc_pkg::PCFC_CMD_RECEIPT_CONFIRM || cmd_op == pcfc_pkg::PCFC_CMD_FETCH;
   assign done_evt = evt_valid && evt_code == pcfc_pkg::PCFC_EVT_CMD_DONE;
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) started <= 1'b0;
      else if (evt_valid && evt_ready && evt_code == pcfc_pkg::PCFC_EVT_STARTUP) started <= 1'b1;
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) sys_pend <= 1'b0;
      else if (take && !is_data) sys_pend <= 1'b1;
      else if (done_evt && evt_ready) sys_pend <= 1'b0;
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) last_op <= 4'h0;
      else if (take) last_op <= cmd_op;
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   sequence s_startup;
      evt_valid && evt_code == pcfc_pkg::PCFC_EVT_STARTUP && evt_arg == 8'(QUEUE_DEPTH);
   endsequence
   sequence s_data_answer;
      evt_valid && (evt_code == pcfc_pkg::PCFC_EVT_CREDIT || evt_code == pcfc_pkg::PCFC_EVT_FAULT);
   endsequence
   property p_startup;
      $fell(reset_in) |-> ##[0:3] s_startup;
   endproperty
   property p_ready_gate;
      !started |-> !cmd_ready;
   endproperty
   property p_one_cmd;
      take |=> !cmd_ready;
   endproperty
   property p_done_src;
      done_evt |-> sys_pend && evt_arg == {4'h0, last_op};
   endproperty
   property p_done_lat;
      take && !is_data |-> ##[1:20] done_evt;
   endproperty
   property p_data_ans;
      take && is_data |-> ##[1:20] s_data_answer;
   endproperty
   property p_avail_maps;
      evt_valid && evt_code == pcfc_pkg::PCFC_EVT_AVAIL |-> evt_closed == ~evt_open;
   endproperty
   property p_fault_code;
      evt_valid && evt_code == pcfc_pkg::PCFC_EVT_FAULT |->
         evt_arg == pcfc_pkg::PCFC_STATUS_NO_CREDIT || evt_arg == pcfc_pkg::PCFC_STATUS_CLOSED;
   endproperty
   property p_credit_arg;
      evt_valid && evt_code == pcfc_pkg::PCFC_EVT_CREDIT |->
         evt_arg >= 8'h01 && evt_arg <= 8'(QUEUE_DEPTH);
   endproperty
   a_startup: assert property (p_startup) else $error("startup notice missing");
   a_ready_gate: assert property (p_ready_gate) else $error("ready before startup");
   a_one_cmd: assert property (p_one_cmd) else $error("second command taken");
   a_done_src: assert property (p_done_src) else $error("done without command");
   a_done_lat: assert property (p_done_lat) else $error("done late");
   a_data_ans: assert property (p_data_ans) else $error("data answer late");
   a_avail_maps: assert property (p_avail_maps) else $error("bitmaps disagree");
   a_fault_code: assert property (p_fault_code) else $error("bad fault code");
   a_credit_arg: assert property (p_credit_arg) else $error("bad credit count");
endmodule
`default_nettype wire

// ### pcfc_device.sv
`timescale 1ns/1ps
`default_nettype none
module pcfc_device #(
   parameter int QUEUE_DEPTH = pcfc_pkg::PCFC_QUEUE_DEPTH,
   parameter int EXEC_CYCLES = 4
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic connected_in,
   input wire logic discovery_done_in,
   input wire logic [7:0] peer_open_in,
   input wire logic [7:0] needs_disc_in,
   input wire logic [7:0] needs_peer_open_in,
   input wire logic [7:0] needs_host_open_in,
   input wire logic [7:0] inbound_in,
   output logic [7:0] bound_out,
   output logic exec_pulse_out,
   output logic [3:0] exec_op_out,
   output logic [2:0] exec_chan_out,
   pcfc_if.device link
);
   initial begin
      if (QUEUE_DEPTH < 1 || QUEUE_DEPTH > 15 || EXEC_CYCLES < 1 || EXEC_CYCLES > 255) begin
         $error("pcfc_device: bad parameter");
      end
   end
   // ----------------------------------------------------------------
   // Pin synchronisers (three stages, second and third agree)
   // ----------------------------------------------------------------
   logic [10:0] s1, s2, s3, pin;
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         s1 <= 11'h000;
         s2 <= 11'h000;
         s3 <= 11'h000;
         pin <= 11'h000;
      end else if (clk_en_in) begin
         s1 <= {connected_in, discovery_done_in, peer_open_in, 1'b0};
         s2 <= s1;
         s3 <= s2;
         pin <= (s2 & s3) | (pin & (s2 | s3));
      end
   end
   wire conn = pin[10];
   wire disc = pin[9];
   wire [7:0] peer_open = pin[8:1];
   // ----------------------------------------------------------------
   // Channel availability
   // ----------------------------------------------------------------
   logic started, startup_sent, conn_d;
   logic [7:0] host_open, open_map, reported;
   logic report_due, lost_due;
   logic [7:0] next_open;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         next_open[i] = conn && (!needs_disc_in[i] || bound_out[i])
            && (!needs_peer_open_in[i] || peer_open[i])
            && (!needs_host_open_in[i] || host_open[i]);
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bound_out <= 8'h00;
      end else if (clk_en_in) begin
         if (!conn) begin
            bound_out <= 8'h00;
         end else if (disc) begin
            bound_out <= 8'hFF;
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         open_map <= 8'h00;
         conn_d <= 1'b0;
      end else if (clk_en_in) begin
         open_map <= next_open;
         conn_d <= conn;
      end
   end
   // ----------------------------------------------------------------
   // Command intake and in-order execution
   // ----------------------------------------------------------------
   logic busy;
   logic [7:0] exec_cnt;
   logic [3:0] op;
   logic [2:0] chan;
   logic [3:0] queued, freed;
   logic done_due, fault_due;
   logic [7:0] fault_code;
   logic [3:0] cur;
   logic evt_fire;
   wire [3:0] returned = (evt_fire && link.evt_code == pcfc_pkg::PCFC_EVT_CREDIT)
      ? link.evt_arg[3:0] : 4'h0;
   function automatic logic is_data(input logic [3:0] c);
      return c == pcfc_pkg::PCFC_CMD_TRANSMIT || c == pcfc_pkg::PCFC_CMD_RECEIPT_CONFIRM
         || c == pcfc_pkg::PCFC_CMD_FETCH;
   endfunction
   // One command at a time keeps arrival order
   assign link.cmd_ready = started && !busy && !done_due && !fault_due;
   wire take = link.cmd_valid && link.cmd_ready && clk_en_in;
   wire data_ok = queued < 4'(QUEUE_DEPTH) && open_map[link.cmd_chan];
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         busy <= 1'b0;
         exec_cnt <= 8'h00;
         op <= 4'h0;
         chan <= 3'h0;
         queued <= 4'h0;
         freed <= 4'h0;
         host_open <= 8'h00;
         fault_due <= 1'b0;
         done_due <= 1'b0;
         fault_code <= 8'h00;
      end else if (clk_en_in) begin
         if (take && is_data(link.cmd_op) && !data_ok) begin
            fault_due <= 1'b1;
            fault_code <= (queued >= 4'(QUEUE_DEPTH)) ? pcfc_pkg::PCFC_STATUS_NO_CREDIT
               : pcfc_pkg::PCFC_STATUS_CLOSED;
         end else if (take) begin
            busy <= 1'b1;
            op <= link.cmd_op;
            chan <= link.cmd_chan;
            exec_cnt <= 8'(EXEC_CYCLES);
         end else if (busy) begin
            exec_cnt <= exec_cnt - 8'h01;
            if (exec_cnt == 8'h01) begin
               busy <= 1'b0;
               if (!is_data(op)) begin
                  done_due <= 1'b1;
               end
               if (op == pcfc_pkg::PCFC_CMD_REMOTE_OPEN) begin
                  host_open[chan] <= 1'b1;
               end
            end
         end
         // Fired code, not current pick: a newer event may outrank it meanwhile
         if (evt_fire && link.evt_code == pcfc_pkg::PCFC_EVT_FAULT) begin
            fault_due <= 1'b0;
         end
         if (evt_fire && link.evt_code == pcfc_pkg::PCFC_EVT_CMD_DONE) begin
            done_due <= 1'b0;
         end
         // Intake, completion and credit return may share one edge
         queued <= queued + {3'h0, take && is_data(link.cmd_op) && data_ok} - returned;
         freed <= freed + {3'h0, busy && exec_cnt == 8'h01 && is_data(op)} - returned;
         if (!conn) begin
            host_open <= 8'h00;
         end
      end
   end
   // ----------------------------------------------------------------
   // Event selection
   // ----------------------------------------------------------------
   always_comb begin
      if (!startup_sent) begin
         cur = pcfc_pkg::PCFC_EVT_STARTUP;
      end else if (lost_due) begin
         cur = pcfc_pkg::PCFC_EVT_LINK_LOST;
      end else if (fault_due) begin
         cur = pcfc_pkg::PCFC_EVT_FAULT;
      end else if (done_due) begin
         cur = pcfc_pkg::PCFC_EVT_CMD_DONE;
      end else if (report_due) begin
         cur = pcfc_pkg::PCFC_EVT_AVAIL;
      end else begin
         cur = pcfc_pkg::PCFC_EVT_CREDIT;
      end
   end
   wire pending = !startup_sent || lost_due || fault_due || done_due || report_due
      || (freed != 4'h0 && !busy);
   assign evt_fire = link.evt_valid && link.evt_ready && clk_en_in;
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         started <= 1'b0;
         startup_sent <= 1'b0;
         lost_due <= 1'b0;
         report_due <= 1'b0;
         reported <= 8'h00;
         link.evt_valid <= 1'b0;
         link.evt_code <= 4'h0;
         link.evt_arg <= 8'h00;
         link.evt_open <= 8'h00;
         link.evt_closed <= 8'h00;
      end else if (clk_en_in) begin
         if (open_map != reported) begin
            report_due <= 1'b1;
         end
         if (conn_d && !conn) begin
            lost_due <= 1'b1;
         end
         if (evt_fire) begin
            link.evt_valid <= 1'b0;
            if (link.evt_code == pcfc_pkg::PCFC_EVT_STARTUP) begin
               startup_sent <= 1'b1;
               started <= 1'b1;
            end
            if (link.evt_code == pcfc_pkg::PCFC_EVT_LINK_LOST) begin
               lost_due <= conn_d && !conn;
            end
            if (link.evt_code == pcfc_pkg::PCFC_EVT_AVAIL) begin
               report_due <= open_map != link.evt_open;
            end
         end else if (!link.evt_valid && pending) begin
            link.evt_valid <= 1'b1;
            link.evt_code <= cur;
            link.evt_open <= open_map;
            link.evt_closed <= ~open_map & ~8'h00;
            unique case (cur)
               pcfc_pkg::PCFC_EVT_STARTUP: link.evt_arg <= 8'(QUEUE_DEPTH);
               pcfc_pkg::PCFC_EVT_FAULT: link.evt_arg <= fault_code;
               pcfc_pkg::PCFC_EVT_CREDIT: link.evt_arg <= {4'h0, freed};
               pcfc_pkg::PCFC_EVT_CMD_DONE: link.evt_arg <= {4'h0, op};
               default: link.evt_arg <= 8'h00;
            endcase
            if (cur == pcfc_pkg::PCFC_EVT_AVAIL) begin
               reported <= open_map;
            end
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         exec_pulse_out <= 1'b0;
         exec_op_out <= 4'h0;
         exec_chan_out <= 3'h0;
      end else if (clk_en_in) begin
         exec_pulse_out <= busy && exec_cnt == 8'h01;
         exec_op_out <= op;
         exec_chan_out <= chan;
      end
   end
endmodule
`default_nettype wire

// ### pcfc_host.sv
`timescale 1ns/1ps
`default_nettype none
module pcfc_host #(
   parameter longint TIMEOUT_CYC = pcfc_pkg::PCFC_CREDIT_TIMEOUT_CYC
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic clk_en_in,
   input wire logic req_valid_in,
   input wire logic [3:0] req_op_in,
   input wire logic [2:0] req_chan_in,
   output logic req_ready_out,
   output logic [7:0] credits_out,
   output logic [7:0] open_out,
   output logic [7:0] closed_out,
   output logic evt_pulse_out,
   output logic [3:0] evt_code_out,
   output logic [7:0] evt_arg_out,
   pcfc_if.host link
);
   initial begin
      if (TIMEOUT_CYC < 1) begin
         $error("pcfc_host: bad timeout");
      end
   end
   logic started, sys_wait, any_open, timer_on, disc_due;
   logic [39:0] timer;
   wire is_data = req_op_in == pcfc_pkg::PCFC_CMD_TRANSMIT
      || req_op_in == pcfc_pkg::PCFC_CMD_RECEIPT_CONFIRM
      || req_op_in == pcfc_pkg::PCFC_CMD_FETCH;
   wire allowed = started && !disc_due
      && (is_data ? (any_open && credits_out != 8'h00 && open_out[req_chan_in])
         : !sys_wait);
   assign link.cmd_valid = disc_due || (req_valid_in && allowed);
   assign link.cmd_op = disc_due ? pcfc_pkg::PCFC_CMD_DISCONNECT : req_op_in;
   assign link.cmd_chan = req_chan_in;
   assign link.evt_ready = 1'b1;
   assign req_ready_out = !disc_due && allowed && link.cmd_ready;
   wire sent = link.cmd_valid && link.cmd_ready && clk_en_in;
   wire got = link.evt_valid && clk_en_in;
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         started <= 1'b0;
         sys_wait <= 1'b0;
         any_open <= 1'b0;
         credits_out <= 8'h00;
         open_out <= 8'h00;
         closed_out <= 8'h00;
      end else if (clk_en_in) begin
         if (sent && !(is_data && !disc_due)) begin
            sys_wait <= 1'b1;
         end
         if (sent && is_data && !disc_due) begin
            credits_out <= credits_out - 8'h01;
         end
         if (got) begin
            unique case (link.evt_code)
               pcfc_pkg::PCFC_EVT_STARTUP: begin
                  started <= 1'b1;
                  credits_out <= link.evt_arg;
                  open_out <= 8'h00;
               end
               pcfc_pkg::PCFC_EVT_AVAIL: begin
                  open_out <= link.evt_open;
                  closed_out <= link.evt_closed;
                  any_open <= any_open || link.evt_open != 8'h00;
               end
               pcfc_pkg::PCFC_EVT_LINK_LOST: begin
                  open_out <= 8'h00;
                  any_open <= 1'b0;
                  sys_wait <= 1'b0;
               end
               pcfc_pkg::PCFC_EVT_CREDIT: credits_out <= credits_out
                  - ((sent && is_data && !disc_due) ? 8'h01 : 8'h00) + link.evt_arg;
               // Refused command never took a slot, so its credit comes back
               pcfc_pkg::PCFC_EVT_FAULT: credits_out <= credits_out
                  - ((sent && is_data && !disc_due) ? 8'h01 : 8'h00) + 8'h01;
               pcfc_pkg::PCFC_EVT_CMD_DONE: sys_wait <= 1'b0;
               default: ;
            endcase
         end
      end
   end
   // Credit watchdog: restarts on each data command, stops on return; a return in the same cycle wins
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         timer_on <= 1'b0;
         timer <= 40'h0;
         disc_due <= 1'b0;
      end else if (clk_en_in) begin
         if (got && (link.evt_code == pcfc_pkg::PCFC_EVT_CREDIT
            || link.evt_code == pcfc_pkg::PCFC_EVT_FAULT)) begin
            timer_on <= 1'b0;
         end else if (sent && is_data && !disc_due) begin
            timer_on <= 1'b1;
            timer <= 40'h0;
         end else if (timer_on) begin
            timer <= timer + 40'h1;
            if (timer == 40'(TIMEOUT_CYC - 1)) begin
               disc_due <= 1'b1;
               timer_on <= 1'b0;
            end
         end
         if (disc_due && sent) begin
            disc_due <= 1'b0;
         end
      end
   end
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         evt_pulse_out <= 1'b0;
         evt_code_out <= 4'h0;
         evt_arg_out <= 8'h00;
      end else if (clk_en_in) begin
         evt_pulse_out <= got;
         evt_code_out <= link.evt_code;
         evt_arg_out <= link.evt_arg;
      end
   end
endmodule
`default_nettype wire

// ### pcfc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pcfc_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [3:0] cmd_op;
   logic [2:0] cmd_chan;
   logic evt_valid;
   logic evt_ready;
   logic [3:0] evt_code;
   logic [7:0] evt_arg;
   logic [7:0] evt_open;
   logic [7:0] evt_closed;
   modport device(input cmd_valid, cmd_op, cmd_chan, evt_ready,
      output cmd_ready, evt_valid, evt_code, evt_arg, evt_open, evt_closed);
   modport host(output cmd_valid, cmd_op, cmd_chan, evt_ready,
      input cmd_ready, evt_valid, evt_code, evt_arg, evt_open, evt_closed);
endinterface
`default_nettype wire

// ### pcfc_pkg.sv
// Contract
// - No receive-channel fault; link loss gives notice
// - Bind remote channels after discovery succeeds
// - Report carries open and closed bitmaps
// - Host opens closed inbound; next report shows
// - Peer-opened outbound flagged only after instruction
// - Fresh report on every availability change
// - Open only when configuration conditions hold
// - Commands executed strictly first in first out
// - Host keeps one system command outstanding
// - Response only after command fully received
// - Startup notice carries data queue depth
// - Freed slots returned by one credit event
// - Host counts credits, decrements per data command
// - Data command without credit gives fault
// - Credits usable only connected and open
// - Host disconnects after 180 seconds without credit
// - Host silent until startup notice arrives
// - No data until report shows open channel
`default_nettype none
package pcfc_pkg;
   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      PCFC_CMD_SYS_GENERIC = 4'h0,
      PCFC_CMD_DISCONNECT = 4'h1,
      PCFC_CMD_REMOTE_OPEN = 4'h2,
      PCFC_CMD_TRANSMIT = 4'h3,
      PCFC_CMD_RECEIPT_CONFIRM = 4'h4,
      PCFC_CMD_FETCH = 4'h5
   } pcfc_cmd_e;
   typedef enum logic [3:0] {
      PCFC_EVT_STARTUP = 4'h1,
      PCFC_EVT_AVAIL = 4'h2,
      PCFC_EVT_LINK_LOST = 4'h3,
      PCFC_EVT_CREDIT = 4'h4,
      PCFC_EVT_FAULT = 4'h5,
      PCFC_EVT_CMD_DONE = 4'h6
   } pcfc_evt_e;
   localparam logic [7:0] PCFC_STATUS_NO_CREDIT = 8'h8B;
   localparam logic [7:0] PCFC_STATUS_CLOSED = 8'h8C;
   localparam int PCFC_CHANNELS = 8;
   localparam int PCFC_QUEUE_DEPTH = 2;
   localparam int PCFC_CLK_HZ = 40000000;
   localparam longint PCFC_CREDIT_TIMEOUT_S = 180;
   localparam longint PCFC_CREDIT_TIMEOUT_CYC = PCFC_CREDIT_TIMEOUT_S * PCFC_CLK_HZ;
   // Channel configuration: bit per channel
   localparam logic [7:0] PCFC_NEEDS_DISC_RST = 8'hF0;
   localparam logic [7:0] PCFC_NEEDS_PEER_OPEN_RST = 8'h0C;
   localparam logic [7:0] PCFC_NEEDS_HOST_OPEN_RST = 8'h30;
   localparam logic [7:0] PCFC_INBOUND_RST = 8'hF0;
endpackage
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic clk_en = 1'b1;
   logic conn = 1'b0;
   logic disc = 1'b0;
   logic [7:0] peer = 8'h00;
   logic rv = 1'b0;
   logic [3:0] rop = 4'h0;
   logic [2:0] rch = 3'h0;
   wire rrdy, epulse, xpulse;
   wire [7:0] credits, opn, cls, earg, bound;
   wire [3:0] ecode, xop;
   wire [2:0] xch;
   int bad_count = 0;
   int tests_run = 0;
   logic [11:0] evq[$];
   logic [7:0] host_m = 8'h00;
   logic [7:0] last_open = 8'h00;
   logic [7:0] g;
   pcfc_if link ();
   pcfc_device pcfc_device_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
      .clk_en_in(clk_en), .connected_in(conn), .discovery_done_in(disc), .peer_open_in(peer),
      .needs_disc_in(pcfc_pkg::PCFC_NEEDS_DISC_RST),
      .needs_peer_open_in(pcfc_pkg::PCFC_NEEDS_PEER_OPEN_RST),
      .needs_host_open_in(pcfc_pkg::PCFC_NEEDS_HOST_OPEN_RST),
      .inbound_in(pcfc_pkg::PCFC_INBOUND_RST), .bound_out(bound), .exec_pulse_out(xpulse),
      .exec_op_out(xop), .exec_chan_out(xch), .link(link));
   // Timeout kept far above the run so refused commands never trigger recovery
   pcfc_host #(.TIMEOUT_CYC(64'd900000)) pcfc_host_inst (.ref_clk_in(ref_clk_in),
      .reset_in(reset_in), .clk_en_in(clk_en), .req_valid_in(rv), .req_op_in(rop),
      .req_chan_in(rch), .req_ready_out(rrdy), .credits_out(credits), .open_out(opn),
      .closed_out(cls), .evt_pulse_out(epulse), .evt_code_out(ecode), .evt_arg_out(earg),
      .link(link));
   pcfc_assertions #(.QUEUE_DEPTH(2)) pcfc_assertions_inst (.ref_clk_in(ref_clk_in),
      .reset_in(reset_in), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .cmd_op(link.cmd_op), .evt_valid(link.evt_valid), .evt_ready(link.evt_ready),
      .evt_code(link.evt_code), .evt_arg(link.evt_arg), .evt_open(link.evt_open),
      .evt_closed(link.evt_closed));
   always #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      if (epulse === 1'b1) evq.push_back({ecode, earg});
   end
   // ----------------------------------------------------------------
   // Model and checks
   // ----------------------------------------------------------------
   function automatic logic [7:0] open_calc();
      logic [7:0] ok;
      ok = ~(pcfc_pkg::PCFC_NEEDS_DISC_RST & ~{8{disc}});
      ok = ok & ~(pcfc_pkg::PCFC_NEEDS_PEER_OPEN_RST & ~peer);
      ok = ok & ~(pcfc_pkg::PCFC_NEEDS_HOST_OPEN_RST & ~host_m);
      return conn ? ok : 8'h00;
   endfunction
   task automatic test_done();
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_evt(input logic [3:0] code, input logic [7:0] arg, input bit any);
      logic [11:0] e;
      int n;
      n = 0;
      while (evq.size() == 0 && n < 400) begin
         @(posedge ref_clk_in);
         n++;
      end
      tests_run++;
      if (evq.size() == 0) begin
         bad_count++;
         $display("BAD %0t no event, wanted code %h", $time, code);
         test_done();
      end else begin
         e = evq.pop_front();
         g = e[7:0];
         if (e[11:8] !== code || (!any && e[7:0] !== arg)) begin
            bad_count++;
            $display("BAD %0t event %h expected %h %h", $time, e, code, arg);
         end
      end
   endtask
   task automatic avail_check();
      logic [7:0] exp;
      exp = open_calc();
      if (exp !== last_open) begin
         check_evt(pcfc_pkg::PCFC_EVT_AVAIL, 8'h00, 1'b1);
         @(negedge ref_clk_in);
         check_val(opn, exp);
         check_val(cls, ~exp);
         last_open = exp;
      end
   endtask
   task automatic send(input logic [3:0] op, input logic [2:0] ch);
      int n;
      n = 0;
      @(negedge ref_clk_in);
      rv = 1'b1;
      rop = op;
      rch = ch;
      @(posedge ref_clk_in);
      while (rrdy !== 1'b1 && n < 400) begin
         @(posedge ref_clk_in);
         n++;
      end
      @(negedge ref_clk_in);
      rv = 1'b0;
      if (n >= 400) begin
         bad_count++;
         $display("BAD %0t request never taken", $time);
         test_done();
      end
   endtask
   task automatic do_cmd(input logic [3:0] op, input logic [2:0] ch);
      logic [7:0] om;
      om = open_calc();
      if (op >= pcfc_pkg::PCFC_CMD_TRANSMIT) begin
         if (om[ch]) begin
            send(op, ch);
            check_evt(pcfc_pkg::PCFC_EVT_CREDIT, 8'h01, 1'b0);
            check_val({xop, 1'b0, xch}, {op, 1'b0, ch});
            @(negedge ref_clk_in);
            check_val(credits, 8'h02);
         end else begin
            // Host must hold back data for a closed channel
            @(negedge ref_clk_in);
            rv = 1'b1;
            rop = op;
            rch = ch;
            repeat (8) @(negedge ref_clk_in);
            check_val({7'h00, rrdy}, 8'h00);
            rv = 1'b0;
            check_val(8'(evq.size()), 8'h00);
         end
      end else begin
         send(op, ch);
         if (op == pcfc_pkg::PCFC_CMD_REMOTE_OPEN) host_m[ch] = 1'b1;
         check_evt(pcfc_pkg::PCFC_EVT_CMD_DONE, {4'h0, op}, 1'b0);
         check_val({xop, 1'b0, xch}, {op, 1'b0, ch});
         avail_check();
      end
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      int sum;
      logic [3:0] op;
      void'($urandom(3975));
      repeat (8) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      reset_in = 1'b0;
      check_evt(pcfc_pkg::PCFC_EVT_STARTUP, 8'h02, 1'b0);
      @(negedge ref_clk_in);
      check_val(credits, 8'h02);
      conn = 1'b1;
      disc = 1'b1;
      avail_check();
      check_val(bound, 8'hFF);
      do_cmd(pcfc_pkg::PCFC_CMD_REMOTE_OPEN, 3'h4);
      do_cmd(pcfc_pkg::PCFC_CMD_FETCH, 3'h4);
      do_cmd(pcfc_pkg::PCFC_CMD_TRANSMIT, 3'h2);
      @(negedge ref_clk_in);
      peer = 8'h04;
      avail_check();
      send(pcfc_pkg::PCFC_CMD_TRANSMIT, 3'h2);
      send(pcfc_pkg::PCFC_CMD_RECEIPT_CONFIRM, 3'h0);
      sum = 0;
      for (int k = 0; k < 2 && sum < 2; k++) begin
         check_evt(pcfc_pkg::PCFC_EVT_CREDIT, 8'h00, 1'b1);
         sum += g;
      end
      check_val(sum[7:0], 8'h02);
      for (int i = 0; i < 14; i++) begin
         op = 4'($urandom_range(0, 5));
         if (op == pcfc_pkg::PCFC_CMD_DISCONNECT) op = pcfc_pkg::PCFC_CMD_SYS_GENERIC;
         do_cmd(op, 3'($urandom_range(0, 7)));
      end
      @(negedge ref_clk_in);
      conn = 1'b0;
      host_m = 8'h00;
      // Lands after the device saw the loss but before the host heard of it
      repeat (4) @(negedge ref_clk_in);
      send(pcfc_pkg::PCFC_CMD_TRANSMIT, 3'h0);
      check_evt(pcfc_pkg::PCFC_EVT_LINK_LOST, 8'h00, 1'b1);
      check_evt(pcfc_pkg::PCFC_EVT_FAULT, pcfc_pkg::PCFC_STATUS_CLOSED, 1'b0);
      avail_check();
      do_cmd(pcfc_pkg::PCFC_CMD_TRANSMIT, 3'h0);
      @(negedge ref_clk_in);
      conn = 1'b1;
      avail_check();
      do_cmd(pcfc_pkg::PCFC_CMD_FETCH, 3'h5);
      // Freeze both ends briefly; nothing in flight may move
      clk_en = 1'b0;
      repeat (5) @(negedge ref_clk_in);
      clk_en = 1'b1;
      repeat (20) @(negedge ref_clk_in);
      check_val(credits, 8'h02);
      check_val(8'(evq.size()), 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
